// ### hw/slave_ic_pkg.sv
// Shared constants and types for the cascaded slave interrupt controller
package slave_ic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NSRC = 6;
  localparam logic [5:0] SRC_VALID = 6'h3D;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] VECTOR_OFS = 8'h20;
  localparam logic [7:0] LEVEL_CLEAR_OFS = 8'h22;
  localparam logic [7:0] MASK_OFS = 8'h28;
  localparam logic [7:0] THRESHOLD_OFS = 8'h2A;
  localparam logic [7:0] IN_SERVICE_OFS = 8'h2C;
  localparam logic [7:0] REQUEST_OFS = 8'h2E;
  localparam logic [7:0] STATUS_OFS = 8'h30;
  localparam logic [7:0] CTRL_BASE_OFS = 8'h32;
  localparam logic [7:0] CTRL_STEP = 8'h02;
  localparam logic [7:0] MODE_OFS = 8'hFE;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_SLAVE_BIT = 14;
  localparam int CW_MASK_BIT = 3;
  localparam int VEC_FIELD_LSB = 3;
  localparam int STATUS_HALT_BIT = 15;
  localparam int TIMER0_IDX = 0;
  localparam int TIMER1_IDX = 4;
  localparam int TIMER2_IDX = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] PRIORITY_RST = 3'h7;
  localparam logic [5:0] MASK_RST = 6'h3F;
  localparam logic [2:0] THRESHOLD_RST = 3'h7;
  localparam logic [2:0] NO_SERVICE_LEVEL = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [2:0] level_t;

  typedef struct packed {
    logic special_nesting_bit;
    logic cascade_bit;
    logic trigger_mode_bit;
    level_t priority_field;
  } ctrl_word_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_TAKE = 2'b01,
    ACK_HOLD = 2'b11
  } ack_state_t;

endpackage

// ### hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pin and clean level
  input wire logic pin_in,
  output logic level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Only the second and third stages are compared; the first feeds the second alone
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.level = s_r.s3;
    end
  end

  // Synchronous reset to a quiet pin
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.level;

endmodule

// ### hw/level_pick.sv
// Picks the eligible source with the smallest priority level
`timescale 1ns/100ps
module level_pick (
  // Candidates
  input wire logic [5:0] eligible,
  input wire slave_ic_pkg::level_t levels [6],
  // Winner
  output logic win_valid,
  output logic [5:0] win_onehot,
  output slave_ic_pkg::level_t win_level
);

  logic [5:0] beaten;

  // A source wins when no other eligible source is more urgent; ties go to the lower index
  for (genvar i = 0; i < slave_ic_pkg::NSRC; i++) begin : g_src
    always_comb begin
      beaten[i] = 1'b0;
      for (int j = 0; j < slave_ic_pkg::NSRC; j++) begin
        if (eligible[j] && ((levels[j] < levels[i]) || ((levels[j] == levels[i]) && (j < i)))) begin
          beaten[i] = 1'b1;
        end
      end
    end
    assign win_onehot[i] = eligible[i] && !beaten[i];
  end

  // Winner level from the one-hot choice
  always_comb begin
    win_level = slave_ic_pkg::NO_SERVICE_LEVEL;
    for (int k = 0; k < slave_ic_pkg::NSRC; k++) begin
      if (win_onehot[k]) begin
        win_level = levels[k];
      end
    end
  end

  assign win_valid = |eligible;

endmodule

// ### hw/slave_int_ctrl.sv
// Cascaded slave interrupt controller: priority, nesting, vectors, level clear
// Function
// - Each timer has its own mask, in-service bit and control word.
// - First interrupt pin carries the master's output to the processor.
// - Fourth pin drives the slave request out to the master.
// - Outside logic decodes cascade address; second pin is slave select.
// - Vector passes internally on acknowledge; outside logic gives bus ready.
// - Third pin is the acknowledge output toward the master.
// - After acknowledge, lower levels are held off; equal or higher pass.
// - Vector is five programmable upper bits plus three level bits.
// - Write at 20H loads the five-bit upper vector field.
// - Level written at 22H clears the in-service bit of that level.
// - The level clear register is write-only; each write is a command.
// - In-service register read/write; bits 2,3 DMA; bits 0,4,5 timers.
// - In-service bit sets when the processor acknowledges the source.
// - Request bit sets on source request, clears on acknowledge.
// - Mask register and control word mask bits share one storage.
// - Each source control word has 3-bit priority and a mask bit.
// - Level threshold keeps lower-priority levels from service.
// - Status register behaves as in normal mode.
// - Reset clears nesting, trigger, cascade bits; starts in normal mode.
// - Reset sets every priority field to 111.
// - Reset clears service and requests, sets masks and threshold ones.
`timescale 1ns/100ps
module slave_int_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire slave_ic_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Internal sources, one-cycle pulses
  input wire logic [5:0] src_req,
  // Processor side
  input wire logic cpu_ack,
  input wire logic bus_ready,
  output logic cpu_int_out,
  output logic [7:0] vector_out,
  output logic vector_valid,
  output logic dma_halt,
  // Pins toward master and decode logic
  input wire logic master_int_in,
  input wire logic slave_select_in,
  output logic slave_request_out,
  output logic acknowledge_out_n
);

  typedef struct packed {
    logic slave;
    logic halt;
    logic [4:0] vec_base;
    slave_ic_pkg::level_t threshold;
    logic [5:0] mask;
    logic [5:0] req;
    logic [5:0] is;
    slave_ic_pkg::ctrl_word_t [5:0] ctrl;
    slave_ic_pkg::ack_state_t st;
    logic [7:0] vec;
    logic vec_valid;
    logic [2:0] vec_src;
    logic [15:0] rdata;
  } ic_state_t;

  ic_state_t s_r;
  ic_state_t s_nxt;
  logic master_int_q;
  logic select_q;
  slave_ic_pkg::level_t levels [6];
  slave_ic_pkg::level_t is_min;
  slave_ic_pkg::level_t win_level;
  logic [5:0] eligible;
  logic [5:0] win_onehot;
  logic win_valid;
  logic ack_take;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync u_master_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(master_int_in),
    .level_out(master_int_q)
  );

  pin_sync u_select_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(slave_select_in),
    .level_out(select_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Eligibility: mask, threshold and nesting limit
  always_comb begin
    is_min = slave_ic_pkg::NO_SERVICE_LEVEL;
    for (int i = slave_ic_pkg::NSRC - 1; i >= 0; i--) begin
      levels[i] = s_r.ctrl[i].priority_field;
      if (s_r.is[i] && (levels[i] < is_min)) begin
        is_min = levels[i];
      end
    end
    for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
      eligible[i] = s_r.req[i] && !s_r.mask[i]
        && (levels[i] <= s_r.threshold)
        && (levels[i] <= is_min);
    end
  end

  // Most urgent eligible source; smallest level wins
  level_pick u_pick (
    .eligible(eligible),
    .levels(levels),
    .win_valid(win_valid),
    .win_onehot(win_onehot),
    .win_level(win_level)
  );

  // Acknowledge only counts when this slave is the one the master addressed
  assign ack_take = (s_r.st == slave_ic_pkg::ACK_TAKE) && select_q && win_valid && s_r.slave;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes first, hardware sets last so sets win
  always_comb begin
    s_nxt = s_r;
    s_nxt.vec_valid = 1'b0;
    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        slave_ic_pkg::MODE_OFS: begin
          s_nxt.slave = reg_req.wdata[slave_ic_pkg::MODE_SLAVE_BIT];
        end
        slave_ic_pkg::VECTOR_OFS: begin
          s_nxt.vec_base = reg_req.wdata[slave_ic_pkg::VEC_FIELD_LSB +: 5];
        end
        slave_ic_pkg::LEVEL_CLEAR_OFS: begin
          for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
            if (s_r.ctrl[i].priority_field == reg_req.wdata[2:0]) begin
              s_nxt.is[i] = 1'b0;
            end
          end
        end
        slave_ic_pkg::MASK_OFS: begin
          s_nxt.mask = reg_req.wdata[5:0] & slave_ic_pkg::SRC_VALID;
        end
        slave_ic_pkg::THRESHOLD_OFS: begin
          s_nxt.threshold = reg_req.wdata[2:0];
        end
        slave_ic_pkg::IN_SERVICE_OFS: begin
          s_nxt.is = reg_req.wdata[5:0] & slave_ic_pkg::SRC_VALID;
        end
        slave_ic_pkg::STATUS_OFS: begin
          // Writing a timer request bit raises that timer's request
          s_nxt.halt = reg_req.wdata[slave_ic_pkg::STATUS_HALT_BIT];
          s_nxt.req[slave_ic_pkg::TIMER0_IDX] = s_r.req[slave_ic_pkg::TIMER0_IDX] | reg_req.wdata[0];
          s_nxt.req[slave_ic_pkg::TIMER1_IDX] = s_r.req[slave_ic_pkg::TIMER1_IDX] | reg_req.wdata[1];
          s_nxt.req[slave_ic_pkg::TIMER2_IDX] = s_r.req[slave_ic_pkg::TIMER2_IDX] | reg_req.wdata[2];
        end
        default: begin
          for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
            if (slave_ic_pkg::SRC_VALID[i]
                && reg_req.addr == slave_ic_pkg::CTRL_BASE_OFS + slave_ic_pkg::CTRL_STEP * 8'(i)) begin
              // Bit 3 is the mask and lives in the shared mask vector, not in the word
              s_nxt.ctrl[i] = {reg_req.wdata[6:4], reg_req.wdata[2:0]};
              s_nxt.mask[i] = reg_req.wdata[slave_ic_pkg::CW_MASK_BIT];
            end
          end
        end
      endcase
    end
    // Acknowledge sequence toward the master
    case (s_r.st)
      slave_ic_pkg::ACK_IDLE: begin
        if (cpu_ack && s_r.slave) begin
          s_nxt.st = slave_ic_pkg::ACK_TAKE;
        end
      end
      slave_ic_pkg::ACK_TAKE: begin
        if (ack_take) begin
          s_nxt.vec = {s_r.vec_base, win_level};
          s_nxt.vec_valid = 1'b1;
          for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
            if (win_onehot[i]) begin
              s_nxt.vec_src = 3'(i);
            end
          end
        end
        s_nxt.st = slave_ic_pkg::ACK_HOLD;
      end
      slave_ic_pkg::ACK_HOLD: begin
        // Bus ready is supplied from outside; hold acknowledge until it comes
        if (bus_ready) begin
          s_nxt.st = slave_ic_pkg::ACK_IDLE;
        end
      end
      default: begin
        s_nxt.st = slave_ic_pkg::ACK_IDLE;
      end
    endcase
    // Request clear on acknowledge, then new requests and service set on top
    if (ack_take) begin
      s_nxt.req = s_nxt.req & ~win_onehot;
    end
    s_nxt.req = s_nxt.req | (src_req & slave_ic_pkg::SRC_VALID);
    if (ack_take) begin
      s_nxt.is = s_nxt.is | win_onehot;
    end
    // Reads: level clear register has no readback
    s_nxt.rdata = s_r.rdata;
    if (reg_req.rd) begin
      s_nxt.rdata = 16'h0000;
      case (reg_req.addr)
        slave_ic_pkg::MODE_OFS: s_nxt.rdata[slave_ic_pkg::MODE_SLAVE_BIT] = s_r.slave;
        slave_ic_pkg::VECTOR_OFS: s_nxt.rdata[slave_ic_pkg::VEC_FIELD_LSB +: 5] = s_r.vec_base;
        slave_ic_pkg::LEVEL_CLEAR_OFS: s_nxt.rdata = 16'h0000;
        slave_ic_pkg::MASK_OFS: s_nxt.rdata[5:0] = s_r.mask;
        slave_ic_pkg::THRESHOLD_OFS: s_nxt.rdata[2:0] = s_r.threshold;
        slave_ic_pkg::IN_SERVICE_OFS: s_nxt.rdata[5:0] = s_r.is;
        slave_ic_pkg::REQUEST_OFS: s_nxt.rdata[5:0] = s_r.req;
        slave_ic_pkg::STATUS_OFS: begin
          s_nxt.rdata[slave_ic_pkg::STATUS_HALT_BIT] = s_r.halt;
          s_nxt.rdata[2:0] = {s_r.req[slave_ic_pkg::TIMER2_IDX], s_r.req[slave_ic_pkg::TIMER1_IDX],
                              s_r.req[slave_ic_pkg::TIMER0_IDX]};
        end
        default: begin
          for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
            if (slave_ic_pkg::SRC_VALID[i]
                && reg_req.addr == slave_ic_pkg::CTRL_BASE_OFS + slave_ic_pkg::CTRL_STEP * 8'(i)) begin
              s_nxt.rdata[6:4] = s_r.ctrl[i][5:3];
              s_nxt.rdata[2:0] = s_r.ctrl[i][2:0];
              s_nxt.rdata[slave_ic_pkg::CW_MASK_BIT] = s_r.mask[i];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
      for (int i = 0; i < slave_ic_pkg::NSRC; i++) begin
        s_r.ctrl[i].priority_field <= slave_ic_pkg::PRIORITY_RST;
      end
      // The unused source slot stays clear so its mask bit reads as zero
      s_r.mask <= slave_ic_pkg::MASK_RST & slave_ic_pkg::SRC_VALID;
      s_r.threshold <= slave_ic_pkg::THRESHOLD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; normal mode keeps the cascade pins quiet
  assign cpu_int_out = s_r.slave && master_int_q;
  assign slave_request_out = s_r.slave && win_valid;
  assign acknowledge_out_n = (s_r.st == slave_ic_pkg::ACK_IDLE);
  assign vector_out = s_r.vec;
  assign vector_valid = s_r.vec_valid;
  assign dma_halt = s_r.halt;
  assign reg_rdata = s_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ack_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cpu_ack && s_r.slave && s_r.st == slave_ic_pkg::ACK_IDLE |=> !acknowledge_out_n [*2])
    else $error("acknowledge not driven after cpu acknowledge");
  req_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_r.slave && eligible != 6'h00 |-> slave_request_out)
    else $error("slave request missing with eligible source");
  int_pass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_r.slave && $stable(master_int_q) |-> cpu_int_out == master_int_q)
    else $error("master interrupt not passed to processor");
  vec_form_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vector_valid |-> vector_out[7:3] == $past(s_r.vec_base)
      && vector_out[2:0] == s_r.ctrl[s_r.vec_src].priority_field)
    else $error("vector does not match base and level");
  is_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vector_valid |-> s_r.is[s_r.vec_src])
    else $error("in-service bit not set on acknowledge");
  nest_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    win_valid |-> win_level <= is_min && win_level <= s_r.threshold)
    else $error("winner below nesting or threshold limit");
  eoi_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == slave_ic_pkg::LEVEL_CLEAR_OFS && !ack_take
      && !(reg_req.addr == slave_ic_pkg::IN_SERVICE_OFS)
      |=> (s_r.is & ~($past(s_r.is) & ~($past(s_r.is)))) == s_r.is
      && ((s_r.is & {s_r.ctrl[5].priority_field == $past(reg_req.wdata[2:0]),
                     s_r.ctrl[4].priority_field == $past(reg_req.wdata[2:0]),
                     s_r.ctrl[3].priority_field == $past(reg_req.wdata[2:0]),
                     s_r.ctrl[2].priority_field == $past(reg_req.wdata[2:0]), 1'b0,
                     s_r.ctrl[0].priority_field == $past(reg_req.wdata[2:0])}) == 6'h00))
    else $error("level clear left an in-service bit set");
  reset_val_a: assert property (@(posedge ref_clk)
    !reset_n |=> s_r.mask == (slave_ic_pkg::MASK_RST & slave_ic_pkg::SRC_VALID) && s_r.is == 6'h00 && s_r.req == 6'h00
      && s_r.threshold == slave_ic_pkg::THRESHOLD_RST && !s_r.slave
      && s_r.ctrl[3].priority_field == slave_ic_pkg::PRIORITY_RST)
    else $error("reset values wrong");

endmodule

// ### testbench/master_pic_model.sv
// Model of the external master controller and its cascade address decode
`timescale 1ns/100ps
module master_pic_model #(
  parameter logic [2:0] SLAVE_ID = 3'h5
) (
  // Clock and bench commands
  input wire logic ref_clk,
  input wire logic [2:0] cascade_addr,
  input wire logic slow_ready,
  // Slave pins
  input wire logic slave_request_out,
  input wire logic acknowledge_out_n,
  output logic master_int_in,
  output logic slave_select_in,
  output logic bus_ready
);
  int wait_cnt;
  logic wobble;

  initial wobble = 1'b0;

  // Master passes the slave request on to the processor a cycle later
  always @(posedge ref_clk) begin
    master_int_in <= slave_request_out;
  end

  // Cascade address decode drives the select pin
  assign slave_select_in = (cascade_addr == SLAVE_ID);

  // Count acknowledge cycles; ready has no pull-up, so it wobbles when idle
  always @(posedge ref_clk) begin
    wobble <= ~wobble;
    if (acknowledge_out_n) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // Ready closes the acknowledge promptly or after a stall
  assign bus_ready = acknowledge_out_n ? wobble : (wait_cnt >= (slow_ready ? 4 : 1));
endmodule

// ### testbench/tb_slave_int_ctrl.sv
// Self-checking bench for the cascaded slave interrupt controller
`timescale 1ns/100ps
module tb_slave_int_ctrl;
  logic ref_clk;
  logic reset_n;
  slave_ic_pkg::reg_req_t reg_req;
  logic [5:0] src_req;
  logic cpu_ack;
  logic [2:0] cascade_addr;
  logic slow_ready;
  logic [15:0] reg_rdata;
  logic [7:0] vector_out;
  logic vector_valid, cpu_int_out, dma_halt, rd_seen;
  logic master_int_in, slave_select_in, bus_ready, slave_request_out, acknowledge_out_n;
  logic [15:0] rd_q[$];
  logic [7:0] vec_q[$];
  logic [4:0] base;
  int bad_count;
  int check_count;
  int k;

  slave_int_ctrl slave_int_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .src_req(src_req), .cpu_ack(cpu_ack), .bus_ready(bus_ready),
    .cpu_int_out(cpu_int_out), .vector_out(vector_out), .vector_valid(vector_valid), .dma_halt(dma_halt),
    .master_int_in(master_int_in), .slave_select_in(slave_select_in),
    .slave_request_out(slave_request_out), .acknowledge_out_n(acknowledge_out_n));

  master_pic_model master_pic_model_inst (.ref_clk(ref_clk), .cascade_addr(cascade_addr),
    .slow_ready(slow_ready), .slave_request_out(slave_request_out), .acknowledge_out_n(acknowledge_out_n),
    .master_int_in(master_int_in), .slave_select_in(slave_select_in), .bus_ready(bus_ready));

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Comparison and run ending
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bus cycles; each leaves one idle edge so no strobe is set twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    @(posedge ref_clk);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
  endtask

  function automatic logic [7:0] ctl(input int i);
    return slave_ic_pkg::CTRL_BASE_OFS + 8'(2 * i);
  endfunction

  // A one-cycle request pulse; the request output is settled on return
  task automatic pulse(input logic [5:0] m);
    @(posedge ref_clk);
    src_req <= m;
    @(posedge ref_clk);
    src_req <= 6'h00;
    #1;
  endtask

  // Processor acknowledge; a vector is expected only when selected
  task automatic ack(input logic sel, input logic [2:0] lvl);
    int n;
    if (sel) vec_q.push_back({base, lvl});
    @(posedge ref_clk);
    cpu_ack <= 1'b1;
    @(posedge ref_clk);
    cpu_ack <= 1'b0;
    #1;
    chk1("ack low", acknowledge_out_n, 1'b0);
    n = 0;
    while (acknowledge_out_n !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk1("ack release", acknowledge_out_n, 1'b1);
  endtask

  // Select needs the synchroniser to settle before the next acknowledge
  task automatic sel_set(input logic [2:0] a, input logic slow);
    cascade_addr <= a;
    slow_ready <= slow;
    repeat (6) @(posedge ref_clk);
  endtask

  // Result watcher: read data the cycle after a read, vectors on their pulse
  always @(posedge ref_clk) begin
    if (rd_seen === 1'b1) check("read", reg_rdata, rd_q.size() ? rd_q.pop_front() : 16'hXXXX);
    if (vector_valid === 1'b1) check("vector", {8'h00, vector_out}, {8'h00, vec_q.size() ? vec_q.pop_front() : 8'hXX});
    rd_seen <= reg_req.rd;
  end

  // Watchdog sized well beyond the roughly 180 cycles the tests use
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    reg_req = '0;
    src_req = 6'h00;
    cpu_ack = 1'b0;
    cascade_addr = 3'h5;
    slow_ready = 1'b0;
    reset_n = 1'b0;
    rd_seen = 1'b0;
    bad_count = 0;
    check_count = 0;
    base = 5'h00;
    void'($urandom(38));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, write-only and unmapped places
    rd(slave_ic_pkg::MASK_OFS, 16'h003D);
    rd(slave_ic_pkg::THRESHOLD_OFS, 16'h0007);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0000);
    rd(slave_ic_pkg::REQUEST_OFS, 16'h0000);
    rd(slave_ic_pkg::MODE_OFS, 16'h0000);
    for (k = 0; k < 6; k++) if (k != 1) rd(ctl(k), 16'h000F);
    rd(slave_ic_pkg::LEVEL_CLEAR_OFS, 16'h0000);
    rd(8'h10, 16'h0000);
    chk1("normal request", slave_request_out, 1'b0);
    $display("test reset done");
    // Fixed levels equal to source index, shared mask storage
    for (k = 0; k < 6; k++) if (k != 1) wr(ctl(k), 16'(k));
    rd(slave_ic_pkg::MASK_OFS, 16'h0000);
    wr(slave_ic_pkg::MASK_OFS, 16'h0020);
    rd(ctl(5), 16'h000D);
    wr(slave_ic_pkg::STATUS_OFS, 16'h8000);
    chk1("halt", dma_halt, 1'b1);
    rd(slave_ic_pkg::STATUS_OFS, 16'h8000);
    wr(slave_ic_pkg::STATUS_OFS, 16'h0000);
    wr(slave_ic_pkg::IN_SERVICE_OFS, 16'h003F);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h003D);
    wr(slave_ic_pkg::IN_SERVICE_OFS, 16'h0000);
    $display("test registers done");
    // Slave mode, random vector base, masked source held pending
    wr(slave_ic_pkg::MODE_OFS, 16'h4000);
    base = 5'($urandom_range(31, 0));
    wr(slave_ic_pkg::VECTOR_OFS, {8'h00, base, 3'h0});
    rd(slave_ic_pkg::VECTOR_OFS, {8'h00, base, 3'h0});
    pulse(6'h20);
    chk1("masked", slave_request_out, 1'b0);
    rd(slave_ic_pkg::REQUEST_OFS, 16'h0020);
    wr(slave_ic_pkg::MASK_OFS, 16'h0000);
    chk1("unmasked", slave_request_out, 1'b1);
    repeat (6) @(posedge ref_clk);
    chk1("cpu int", cpu_int_out, 1'b1);
    ack(1'b1, 3'h5);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0020);
    rd(slave_ic_pkg::REQUEST_OFS, 16'h0000);
    wr(slave_ic_pkg::LEVEL_CLEAR_OFS, 16'h0005);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0000);
    $display("test mask done");
    // All sources at once: served by level, nesting holds lower levels off
    pulse(6'h3D);
    rd(slave_ic_pkg::REQUEST_OFS, 16'h003D);
    for (k = 0; k < 6; k++) if (k != 1) begin
      ack(1'b1, 3'(k));
      chk1("nest hold", slave_request_out, 1'b0);
      rd(slave_ic_pkg::IN_SERVICE_OFS, 16'(1 << k));
      if (k == 4) begin
        pulse(6'h01);
        chk1("nest pass", slave_request_out, 1'b1);
        ack(1'b1, 3'h0);
        rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0011);
        wr(slave_ic_pkg::LEVEL_CLEAR_OFS, 16'h0000);
      end
      wr(slave_ic_pkg::LEVEL_CLEAR_OFS, 16'(k));
    end
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0000);
    $display("test priority done");
    // Level threshold, unselected acknowledge, slow ready
    wr(slave_ic_pkg::THRESHOLD_OFS, 16'h0002);
    pulse(6'h08);
    chk1("below threshold", slave_request_out, 1'b0);
    wr(slave_ic_pkg::THRESHOLD_OFS, 16'h0003);
    chk1("at threshold", slave_request_out, 1'b1);
    sel_set(3'h2, 1'b0);
    ack(1'b0, 3'h0);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0000);
    sel_set(3'h5, 1'b1);
    ack(1'b1, 3'h3);
    rd(slave_ic_pkg::IN_SERVICE_OFS, 16'h0008);
    $display("test threshold done");
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule
